// file: common/buck_pwm_pkg.sv
// Shared constants and types for the dual-phase buck pulse timing block
package buck_pwm_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_PERIOD = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    // Control register fields and reset value
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Timing, derived from the system clock rate
    localparam int CLK_MHZ = 50;
    localparam int SW_FREQ_KHZ = 300;
    localparam int SW_FREQ_MAX_KHZ = 1000;
    localparam int SW_FREQ_MIN_KHZ = 200;
    localparam int PERIOD_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
    localparam logic [11:0] PERIOD_RESET = 12'(PERIOD_CYC);
    localparam logic [11:0] PERIOD_MIN = 12'(CLK_MHZ * 1000 / SW_FREQ_MAX_KHZ);
    localparam logic [11:0] PERIOD_MAX = 12'(CLK_MHZ * 1000 / SW_FREQ_MIN_KHZ);
    localparam int DEAD_NS = 40;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_OFF_NS = 200;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    // Normalised current codes: 100 mV at the overcurrent point
    localparam logic [9:0] OCL_CODE = 10'h0c8;
    localparam logic [9:0] LL_HI_CODE = 10'h032;
    localparam logic [9:0] LL_LO_CODE = 10'h00a;
    localparam logic [11:0] LL_SPAN = 12'h028;
    // Current amplifier gains, four fractional bits
    localparam logic [5:0] GAIN_ULV = 6'h20;
    localparam logic [5:0] GAIN_LV = 6'h10;
    // Skip caps
    localparam logic [3:0] CAP_LOW = 4'h7;
    localparam logic [3:0] CAP_HIGH = 4'hf;
    // Strap level codes
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_REF = 2'h1;
    localparam logic [1:0] STRAP_3V3 = 2'h2;
    localparam logic [1:0] STRAP_5V = 2'h3;

    typedef enum logic [1:0] {SKIP_CCM, SKIP_AUTO, SKIP_CAP7, SKIP_CAP15} skip_mode_t;
    typedef enum logic {CTL_CURRENT, CTL_RIPPLE} ctl_mode_t;
    typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW, PH_FORCE_OFF} phase_t;
endpackage

// file: verilog/dead_time_driver.sv
// Gate pair driver with dead time between the two switches
`timescale 1ns/1ps
module dead_time_driver
    import buck_pwm_pkg::*;
#(
    parameter int DEAD = DEAD_CYC
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Switch requests
    input wire logic hsReq,
    input wire logic lsReq,
    // Gate outputs
    output logic highSideGate,
    output logic lowSideGate
);
    typedef struct packed {
        logic hs;
        logic ls;
        logic [3:0] gap;
    } drv_state_t;

    drv_state_t st_ff;
    drv_state_t nxt_st;

    // Gap counter is four bits
    if (DEAD < 1 || DEAD > 15)
    begin : g_bad_dead
        $error("dead time count out of range");
    end

    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.hs && !hsReq)
        begin
            nxt_st.hs = 1'b0;
            nxt_st.gap = 4'(DEAD);
        end
        else if (st_ff.ls && !lsReq)
        begin
            nxt_st.ls = 1'b0;
            nxt_st.gap = 4'(DEAD);
        end
        else if (st_ff.gap != 4'h0)
            nxt_st.gap = st_ff.gap - 4'h1;
        else if (hsReq && !st_ff.ls)
            nxt_st.hs = 1'b1;
        else if (lsReq && !st_ff.hs)
            nxt_st.ls = 1'b1;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign highSideGate = st_ff.hs;
    assign lowSideGate = st_ff.ls;

    // Gap both ways
    property p_dead_lo_hi;
        @(posedge clk_sys) disable iff (rst)
        $rose(highSideGate) |-> !$past(lowSideGate, 1) && !$past(lowSideGate, DEAD + 1);
    endproperty
    a_dead_lo_hi: assert property (p_dead_lo_hi) else $error("high side on without dead time");
    property p_dead_hi_lo;
        @(posedge clk_sys) disable iff (rst)
        $rose(lowSideGate) |-> !$past(highSideGate, 1) && !$past(highSideGate, DEAD + 1);
    endproperty
    a_dead_hi_lo: assert property (p_dead_hi_lo) else $error("low side on without dead time");
endmodule

// file: verilog/buck_pwm_core.sv
// Dual-phase buck pulse timing core with skip control and AHB-Lite registers
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - Sync rise starts ch1, fall ch2
// - Internal clock, ch2 half period later
// - Phase offset follows sync high time
// - Skip strap decodes four modes
// - Continuous mode switches every cycle
// - Skip modes hold high until light-load limit
// - Light-load limit ramps 25% to 5%
// - Skipping drops whole clock-aligned pulses
// - Capped skip forces pulse at count
// - Capped overvoltage shortens on-time
// - Full-on cycle gets recharge off-time
// - Dead time between gate transitions
// - Ripple trip ends high-side pulse
// - Ripple mode uses current for limits only
// - Gain normalises overcurrent to fixed code
// - Function strap selects control scheme
// - Current mode: on at start, off at target
module buck_pwm_core
    import buck_pwm_pkg::*;
#(
    parameter logic [11:0] PERIOD_INIT = PERIOD_RESET
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Straps and sync clock
    input wire logic [1:0][1:0] skipModeStrap,
    input wire logic [1:0] functionSelectStrap,
    input wire logic [1:0] overcurrentStrap,
    input wire logic freqSetPin,
    // Per-channel comparators and current sense
    input wire logic [1:0] fbLow,
    input wire logic [1:0] currentTrip,
    input wire logic [1:0] rippleTrip,
    input wire logic [1:0] zeroCross,
    input wire logic [1:0] overVolt,
    input wire logic [1:0][9:0] currentSenseDiff,
    // Gates and normalised current
    output logic [1:0] highSideGate,
    output logic [1:0] lowSideGate,
    output logic [1:0][9:0] currentNorm
);
    typedef struct packed {
        logic [1:0] ctrl;
        logic [11:0] period;
        logic [11:0] cnt;
        logic syncPrev;
        logic strapDone;
        skip_mode_t [1:0] skip;
        ctl_mode_t ctl;
        logic [5:0] gain;
        logic busWr;
        logic [31:0] busAddr;
        logic [31:0] rdata;
        phase_t [1:0] ph;
        logic [1:0][3:0] skipCnt;
        logic [1:0][9:0] llLim;
        logic [1:0][11:0] acc;
        logic [1:0] rampOn;
        logic [1:0] zcSeen;
        logic [1:0][3:0] offCnt;
        logic [1:0][9:0] iNorm;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;
    logic run;
    logic sync;
    logic [11:0] half;
    logic [1:0] start;
    logic [1:0] hsReq;
    logic [1:0] lsReq;
    logic [1:0] capped;

    // Refuse settings the counters cannot hold
    if (PERIOD_INIT < PERIOD_MIN || PERIOD_INIT > PERIOD_MAX || PERIOD_MIN < LL_SPAN || MIN_OFF_CYC > 15)
    begin : g_bad_cfg
        $error("period or off-time setting out of range");
    end

    // Cycle starts
    assign run = st_ff.ctrl[CTRL_RUN_BIT] && st_ff.strapDone;
    assign sync = st_ff.ctrl[CTRL_SYNC_BIT];
    assign half = {1'b0, st_ff.period[11:1]};
    // offset set by sync high time
    assign start[0] = run && (sync ? (freqSetPin && !st_ff.syncPrev) : (st_ff.cnt == 12'h000));
    assign start[1] = run && (sync ? (!freqSetPin && st_ff.syncPrev) : (st_ff.cnt == half));

    // Switch requests per channel
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            hsReq[c] = st_ff.ph[c] == PH_HIGH;
            lsReq[c] = st_ff.ph[c] == PH_LOW || st_ff.ph[c] == PH_FORCE_OFF;
            capped[c] = st_ff.skip[c] == SKIP_CAP7 || st_ff.skip[c] == SKIP_CAP15;
        end
    end

    // Next state
    always_comb
    begin
        logic [15:0] prod;
        logic [12:0] accSum;
        logic modeTrip;
        logic offNow;
        logic [3:0] capMax;
        prod = 16'h0000;
        accSum = 13'h0000;
        modeTrip = 1'b0;
        offNow = 1'b0;
        capMax = CAP_LOW;
        nxt_st = st_ff;
        nxt_st.syncPrev = freqSetPin;
        nxt_st.cnt = (!run || st_ff.cnt >= st_ff.period - 12'h001) ? 12'h000 : st_ff.cnt + 12'h001;
        if (!st_ff.strapDone)
        begin
            nxt_st.strapDone = 1'b1;
            for (int c = 0; c < 2; c++)
            begin
                case (skipModeStrap[c])
                    STRAP_GND: nxt_st.skip[c] = SKIP_CCM;
                    STRAP_REF: nxt_st.skip[c] = SKIP_AUTO;
                    STRAP_3V3: nxt_st.skip[c] = SKIP_CAP7;
                    default: nxt_st.skip[c] = SKIP_CAP15;
                endcase
            end
            nxt_st.ctl = (functionSelectStrap == STRAP_REF || functionSelectStrap == STRAP_3V3) ?
                CTL_RIPPLE : CTL_CURRENT;
            nxt_st.gain = (overcurrentStrap == STRAP_GND || overcurrentStrap == STRAP_REF) ? GAIN_ULV : GAIN_LV;
        end
        for (int c = 0; c < 2; c++)
        begin
            // normalise sensed current
            // Widen both factors first so the product keeps its upper bits
            prod = 16'(currentSenseDiff[c]) * 16'(st_ff.gain);
            nxt_st.iNorm[c] = (prod[15:14] != 2'h0) ? 10'h3ff : prod[13:4];
            capMax = (st_ff.skip[c] == SKIP_CAP15) ? CAP_HIGH : CAP_LOW;
            modeTrip = (st_ff.ctl == CTL_RIPPLE) ? rippleTrip[c] : currentTrip[c];
            accSum = {1'b0, st_ff.acc[c]} + {1'b0, LL_SPAN};
            if (st_ff.rampOn[c])
            begin
                if (accSum >= {1'b0, st_ff.period})
                begin
                    accSum = accSum - {1'b0, st_ff.period};
                    if (st_ff.llLim[c] > LL_LO_CODE)
                        nxt_st.llLim[c] = st_ff.llLim[c] - 10'h001;
                    else
                        nxt_st.rampOn[c] = 1'b0;
                end
                nxt_st.acc[c] = accSum[11:0];
            end
            case (st_ff.ph[c])
                PH_IDLE, PH_LOW:
                begin
                    if (start[c])
                    begin
                        if (st_ff.skip[c] == SKIP_CCM || fbLow[c] || (capped[c] && st_ff.skipCnt[c] >= capMax))
                        begin
                            nxt_st.ph[c] = PH_HIGH;
                            nxt_st.skipCnt[c] = 4'h0;
                            nxt_st.llLim[c] = LL_HI_CODE;
                            nxt_st.acc[c] = 12'h000;
                            nxt_st.rampOn[c] = st_ff.zcSeen[c];
                            nxt_st.zcSeen[c] = 1'b0;
                        end
                        else if (st_ff.ph[c] == PH_IDLE && capped[c] && st_ff.skipCnt[c] < capMax)
                            nxt_st.skipCnt[c] = st_ff.skipCnt[c] + 4'h1;
                    end
                    else if (st_ff.ph[c] == PH_LOW && st_ff.skip[c] != SKIP_CCM && zeroCross[c])
                    begin
                        nxt_st.ph[c] = PH_IDLE;
                        nxt_st.zcSeen[c] = 1'b1;
                    end
                end
                PH_HIGH:
                begin
                    offNow = st_ff.iNorm[c] >= OCL_CODE ||
                        (modeTrip && (st_ff.skip[c] == SKIP_CCM || st_ff.iNorm[c] >= st_ff.llLim[c])) ||
                        (capped[c] && overVolt[c] && st_ff.iNorm[c] >= {1'b0, st_ff.llLim[c][9:1]});
                    if (start[c])
                    begin
                        nxt_st.ph[c] = PH_FORCE_OFF;
                        nxt_st.offCnt[c] = 4'(MIN_OFF_CYC);
                    end
                    else if (offNow)
                        nxt_st.ph[c] = PH_LOW;
                end
                PH_FORCE_OFF:
                begin
                    if (st_ff.offCnt[c] <= 4'h1)
                        nxt_st.ph[c] = PH_HIGH;
                    else
                        nxt_st.offCnt[c] = st_ff.offCnt[c] - 4'h1;
                end
                default: nxt_st.ph[c] = PH_IDLE;
            endcase
            if (!run)
            begin
                nxt_st.ph[c] = PH_IDLE;
                nxt_st.skipCnt[c] = 4'h0;
                nxt_st.rampOn[c] = 1'b0;
                nxt_st.zcSeen[c] = 1'b0;
            end
        end
        // Bus data phase write
        if (st_ff.busWr && st_ff.busAddr == ADDR_CTRL)
            nxt_st.ctrl = hwdata[1:0];
        else if (st_ff.busWr && st_ff.busAddr == ADDR_PERIOD)
        begin
            if (hwdata[31:12] != 20'h00000 || hwdata[11:0] > PERIOD_MAX)
                nxt_st.period = PERIOD_MAX;
            else if (hwdata[11:0] < PERIOD_MIN)
                nxt_st.period = PERIOD_MIN;
            else
                nxt_st.period = hwdata[11:0];
        end
        // Bus address phase
        nxt_st.busWr = 1'b0;
        if (hsel && hready && htrans[1] && hsize == 3'h2)
        begin
            nxt_st.busWr = hwrite;
            nxt_st.busAddr = haddr;
            case (haddr)
                ADDR_CTRL: nxt_st.rdata = {30'h0, st_ff.ctrl};
                ADDR_PERIOD: nxt_st.rdata = {20'h00000, st_ff.period};
                ADDR_STATUS: nxt_st.rdata = {14'h0, st_ff.strapDone, st_ff.skipCnt[1], st_ff.skipCnt[0],
                    st_ff.ph[1], st_ff.ph[0], st_ff.ctl, st_ff.skip[1], st_ff.skip[0]};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RESET;
            st_ff.period <= PERIOD_INIT;
            st_ff.gain <= GAIN_LV;
            st_ff.llLim <= {LL_HI_CODE, LL_HI_CODE};
        end
        else
            st_ff <= nxt_st;
    end

    // Bus answer: no wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign currentNorm = st_ff.iNorm;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Ramp and strap checks
    property p_ramp_start;
        $rose(st_ff.rampOn[0]) |-> st_ff.llLim[0] == LL_HI_CODE ##1 st_ff.llLim[0] <= LL_HI_CODE;
    endproperty
    a_ramp_start: assert property (p_ramp_start) else $error("ramp does not start at upper limit");
    property p_ramp_end;
        $fell(st_ff.rampOn[0]) && run |-> st_ff.llLim[0] == LL_LO_CODE;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("ramp does not end at lower limit");
    property p_strap_cap7;
        $rose(st_ff.strapDone) && $past(skipModeStrap[0]) == STRAP_3V3 |-> st_ff.skip[0] == SKIP_CAP7;
    endproperty
    a_strap_cap7: assert property (p_strap_cap7) else $error("skip strap decoded wrongly");
    property p_strap_ctl;
        $rose(st_ff.strapDone) |-> st_ff.ctl == (($past(functionSelectStrap) == STRAP_REF ||
            $past(functionSelectStrap) == STRAP_3V3) ? CTL_RIPPLE : CTL_CURRENT);
    endproperty
    a_strap_ctl: assert property (p_strap_ctl) else $error("function strap decoded wrongly");
    property p_strap_static;
        st_ff.strapDone |=> $stable(st_ff.skip) && $stable(st_ff.ctl) && $stable(st_ff.gain);
    endproperty
    a_strap_static: assert property (p_strap_static) else $error("strap code changed in operation");
    // Normalised code crosses the trip code exactly where raw current crosses the strap's point
    property p_norm_ocl;
        $past(st_ff.gain) == st_ff.gain && (st_ff.gain == GAIN_LV || st_ff.gain == GAIN_ULV)
            |-> (st_ff.iNorm[0] >= OCL_CODE) ==
            ($past(currentSenseDiff[0]) >= ((st_ff.gain == GAIN_LV) ? OCL_CODE : (OCL_CODE >> 1)));
    endproperty
    a_norm_ocl: assert property (p_norm_ocl) else $error("normalised current wrong at trip point");

    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        // Gate drivers with dead time
        dead_time_driver #(.DEAD(DEAD_CYC)) u_drv (
            .clk_sys(clk_sys),
            .rst(rst),
            .hsReq(hsReq[g]),
            .lsReq(lsReq[g]),
            .highSideGate(highSideGate[g]),
            .lowSideGate(lowSideGate[g])
        );

        sequence s_full_on;
            run && hsReq[g] && start[g];
        endsequence
        sequence s_recharge;
            (st_ff.ph[g] == PH_FORCE_OFF && lsReq[g])[*8] ##[1:4] (hsReq[g] || !run);
        endsequence
        property p_int_align;
            $rose(hsReq[g]) && !sync && $past(sync) == sync && $past(st_ff.ph[g]) != PH_FORCE_OFF
                |-> $past(st_ff.cnt) == ((g == 0) ? 12'h000 : $past(half));
        endproperty
        a_int_align: assert property (p_int_align) else $error("pulse not at internal phase point");
        property p_ext_align;
            $rose(hsReq[g]) && sync && $past(sync) && $past(st_ff.ph[g]) != PH_FORCE_OFF
                |-> $past(st_ff.syncPrev) != $past(freqSetPin) && $past(freqSetPin) == (g == 0);
        endproperty
        a_ext_align: assert property (p_ext_align) else $error("pulse not at sync clock edge");
        property p_skip_whole;
            st_ff.skip[g] != SKIP_CCM && $rose(hsReq[g]) |-> $past(start[g]) || $past(st_ff.ph[g]) == PH_FORCE_OFF;
        endproperty
        a_skip_whole: assert property (p_skip_whole) else $error("skip pulse off clock alignment");
        property p_ccm_every;
            st_ff.skip[g] == SKIP_CCM && start[g] && !hsReq[g] |=> hsReq[g];
        endproperty
        a_ccm_every: assert property (p_ccm_every) else $error("continuous mode skipped a pulse");
        property p_ll_hold;
            st_ff.skip[g] != SKIP_CCM && hsReq[g] && !overVolt[g] && !start[g] && st_ff.iNorm[g] < st_ff.llLim[g]
                |=> hsReq[g];
        endproperty
        a_ll_hold: assert property (p_ll_hold) else $error("high side ended below light-load limit");
        property p_cap_force;
            capped[g] && start[g] && st_ff.ph[g] == PH_IDLE &&
                st_ff.skipCnt[g] == ((st_ff.skip[g] == SKIP_CAP15) ? CAP_HIGH : CAP_LOW) |=> hsReq[g];
        endproperty
        a_cap_force: assert property (p_cap_force) else $error("no forced pulse at skip cap");
        property p_ov_mod;
            capped[g] && overVolt[g] && hsReq[g] && !start[g] && st_ff.iNorm[g] >= {1'b0, st_ff.llLim[g][9:1]}
                |=> st_ff.ph[g] == PH_LOW;
        endproperty
        a_ov_mod: assert property (p_ov_mod) else $error("overvoltage did not shorten on-time");
        property p_recharge;
            s_full_on |=> s_recharge;
        endproperty
        a_recharge: assert property (p_recharge) else $error("no off-time after full-on cycle");
        property p_ripple_off;
            st_ff.ctl == CTL_RIPPLE && st_ff.skip[g] == SKIP_CCM && rippleTrip[g] && hsReq[g] && !start[g]
                |=> st_ff.ph[g] == PH_LOW;
        endproperty
        a_ripple_off: assert property (p_ripple_off) else $error("ripple trip did not end pulse");
        property p_cur_off;
            st_ff.ctl == CTL_CURRENT && st_ff.skip[g] == SKIP_CCM && currentTrip[g] && hsReq[g] && !start[g]
                |=> lsReq[g] && !hsReq[g];
        endproperty
        a_cur_off: assert property (p_cur_off) else $error("current target did not end pulse");
    end
endmodule

// file: sim/gate_load_model.sv
// Switch pair, inductor and external sync clock model
`timescale 1ns/1ps
module gate_load_model
#(
    parameter int SYNC_PER = 40,
    parameter int SYNC_HIGH = 12
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Gates
    input wire logic [1:0] highSideGate,
    input wire logic [1:0] lowSideGate,
    // Sense and sync
    output logic [1:0][9:0] currentSenseDiff = '0,
    output logic [1:0] currentTrip,
    output logic [1:0] zeroCross,
    output logic freqSetPin = 1'b0
);
    int syncCnt = 0;
    // Current rises on the high side, decays on the low side
    always @(posedge clk_sys)
    begin
        syncCnt <= (rst || syncCnt == SYNC_PER - 1) ? 0 : syncCnt + 1;
        freqSetPin <= syncCnt < SYNC_HIGH;
        for (int c = 0; c < 2; c++)
            if (rst)
                currentSenseDiff[c] <= 10'h0;
            else if (highSideGate[c])
                currentSenseDiff[c] <= currentSenseDiff[c] + 10'h8;
            else if (lowSideGate[c])
                currentSenseDiff[c] <= (currentSenseDiff[c] > 10'h4) ? currentSenseDiff[c] - 10'h4 : 10'h0;
    end
    // Comparator outputs
    always_comb
        for (int c = 0; c < 2; c++)
        begin
            currentTrip[c] = currentSenseDiff[c] >= 10'h28;
            zeroCross[c] = lowSideGate[c] && currentSenseDiff[c] == 10'h0;
        end
endmodule

// file: sim/tb_top.sv
// Bench for the buck pulse timing core
`timescale 1ns/1ps
module tb_top;
    import buck_pwm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, freqSetPin;
    logic [31:0] hrdata, q;
    logic [1:0][1:0] skipModeStrap = '0;
    logic [1:0] funcStrap = 2'h0;
    logic [1:0] currentTrip, zeroCross, hs, ls, hsP, lsP;
    logic [1:0][9:0] currentSenseDiff, currentNorm;
    logic [9:0] rawP = 10'h0;
    logic normOn = 1'b0;
    int failures = 0;
    int checks = 0;
    int gap[2] = '{100, 100};
    int t0, t1, t2;
    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;
    buck_pwm_core #(.PERIOD_INIT(12'h032)) dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .skipModeStrap(skipModeStrap),
        .functionSelectStrap(funcStrap), .overcurrentStrap(2'h0), .freqSetPin(freqSetPin), .fbLow(2'h0),
        .currentTrip(currentTrip), .rippleTrip(2'h0), .zeroCross(zeroCross), .overVolt(2'h0),
        .currentSenseDiff(currentSenseDiff), .highSideGate(hs), .lowSideGate(ls), .currentNorm(currentNorm));
    gate_load_model model (.clk_sys(clk_sys), .rst(rst), .highSideGate(hs), .lowSideGate(ls),
        .currentSenseDiff(currentSenseDiff), .currentTrip(currentTrip), .zeroCross(zeroCross),
        .freqSetPin(freqSetPin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tmo(input string msg);
        failures++;
        $display("unexpected at %0t: timeout %s", $time, msg);
        give_verdict();
    endtask
    task automatic waitReady;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
                tmo("bus");
            @(posedge clk_sys);
        end
    endtask
    // One single word transfer, read data left in q
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask
    task automatic waitRise(input int c, output int t);
        int n;
        logic p;
        for (n = 0; n < 1000; n++)
        begin
            p = hs[c];
            @(posedge clk_sys);
            if (hs[c] === 1'b1 && p === 1'b0)
                break;
        end
        if (n == 1000)
            tmo("gate");
        t = int'($time / 20);
    endtask
    // Skips the first pulses, then times ch1, ch2, ch1
    task automatic measure;
        waitRise(0, t0);
        waitRise(1, t1);
        waitRise(0, t0);
        waitRise(1, t1);
        waitRise(0, t2);
    endtask
    task automatic doReset(input logic [1:0] s0, input logic [1:0] s1, input logic [1:0] f);
        rst <= 1'b1;
        skipModeStrap <= {s1, s0};
        funcStrap <= f;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Gap between gate transitions and current scaling
    always @(posedge clk_sys)
    begin
        for (int c = 0; c < 2; c++)
            if (hs[c] | ls[c])
            begin
                if ((hs[c] & ~hsP[c]) | (ls[c] & ~lsP[c]))
                    chk({hs[c] & ls[c], gap[c] >= 3}, 32'h1, "dead time");
                gap[c] = 0;
            end
            else
                gap[c]++;
        if (normOn && !rst)
            chk(currentNorm[0], {rawP, 1'b0}, "current scaling");
        rawP <= currentSenseDiff[0];
        hsP <= hs;
        lsP <= ls;
    end
    // Main sequence
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            doReset(2'(i), 2'(3 - i), 2'(i));
            bus(1'b0, ADDR_STATUS, 32'h0);
            chk(q[4:0], {(i == 1 || i == 2), 2'(3 - i), 2'(i)}, "strap decode");
            chk(q[17], 1'b1, "strap capture");
        end
        $display("test straps done");
        doReset(2'h0, 2'h0, 2'h0);
        normOn = 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h0, "ctrl reset");
        bus(1'b0, ADDR_PERIOD, 32'h0);
        chk(q, 32'h32, "period reset");
        bus(1'b1, ADDR_PERIOD, 32'h12c);
        bus(1'b0, ADDR_PERIOD, 32'h0);
        chk(q, 32'hfa, "period clamp high");
        bus(1'b1, ADDR_PERIOD, 32'ha);
        bus(1'b0, ADDR_PERIOD, 32'h0);
        chk(q, 32'h32, "period clamp low");
        bus(1'b0, 32'h10, 32'h0);
        chk(q, 32'h0, "unmapped read");
        $display("test registers done");
        bus(1'b1, ADDR_CTRL, 32'h1);
        measure();
        chk(t2 - t0, 50, "internal period");
        chk(t1 - t0, 25, "internal phase");
        $display("test internal clock done");
        bus(1'b1, ADDR_CTRL, 32'h3);
        measure();
        chk(t2 - t0, 40, "sync period");
        chk(t1 - t0, 12, "sync phase");
        $display("test sync clock done");
        bus(1'b1, ADDR_CTRL, 32'h0);
        repeat (20) @(posedge clk_sys);
        chk({hs, ls}, 32'h0, "stop");
        $display("test stop done");
        // Capped skip: seven skipped starts, then a forced pulse
        doReset(2'h2, 2'h2, 2'h0);
        bus(1'b1, ADDR_CTRL, 32'h1);
        measure();
        chk(t2 - t0, (int'(CAP_LOW) + 1) * 50, "capped skip period");
        chk(t1 - t0, 25, "skip phase");
        $display("test capped skip done");
        give_verdict();
    end
endmodule
